// ===== src/fpfep_core.sv
// four phase fetch execute pipeline sequencing core
// Notes on behaviour
// [RULE1] the system clock from either internal oscillator is split into four phases per cycle.
// [RULE2] the program counter advances at the start of the fetch phase and the word is fetched then.
// [RULE3] decode and execution happen in the second, third and fourth phases.
// [RULE4] fetch of the next word overlaps execution so plain instructions retire one per cycle.
// [RULE5] any instruction that redirects the program counter takes two instruction cycles.
// [RULE6] a branch gets its target in the first cycle and transfers control in the second.
// [RULE7] an eight bit alu does arithmetic, logic, rotate, inc, dec and branch decisions on acc.
// [RULE8] the counter steps by one per instruction; jumps, calls and reset load a target.
// [RULE9] on skip or redirect the prefetched word is discarded and a dummy cycle replaces it.
// [RULE10] phases advance one per clock, first to fourth, wrap, and restart at first after reset.
`timescale 1ns/1ps
`include "fpfep_regs.svh"
module fpfep_core #(
    parameter int PC_W = `FPFEP_PC_W,
    parameter int INSN_W = `FPFEP_INSN_W
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // program memory
    output logic [PC_W-1:0] o_imem_addr,
    output logic o_imem_rd,
    input wire logic [INSN_W-1:0] i_imem_data,
    // status
    output fpfep_pkg::fpfep_phase_e o_phase,
    output logic [7:0] o_acc,
    output logic o_retire,
    output logic o_dummy
);
    import fpfep_pkg::*;

    fpfep_phase_e phase;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] ret_pc;
    logic [INSN_W-1:0] fetched;
    logic [INSN_W-1:0] ir;
    logic [7:0] acc;
    logic zero;
    logic flush;
    logic squash;
    logic redirect;
    logic [PC_W-1:0] target;
    logic [7:0] next_acc;
    logic next_redirect;
    logic next_skip;
    fpfep_op_e op;

    assign op = fpfep_op_e'(ir[`FPFEP_OP_POS +: `FPFEP_OP_W]);

    // phase generator
    // [RULE10] fixed phase order
    // [RULE1] four phases per cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            phase <= FPFEP_PH_FETCH;
        end else begin
            case (phase)
                FPFEP_PH_FETCH: phase <= FPFEP_PH_DEC;
                FPFEP_PH_DEC: phase <= FPFEP_PH_EXE;
                FPFEP_PH_EXE: phase <= FPFEP_PH_WB;
                FPFEP_PH_WB: phase <= FPFEP_PH_FETCH;
                default: phase <= FPFEP_PH_FETCH;
            endcase
        end
    end

    // execute decision, combinational over the current word
    // [RULE7] eight bit alu
    always_comb begin
        next_acc = acc;
        next_redirect = 1'b0;
        next_skip = 1'b0;
        case (op)
            FPFEP_OP_ALU: next_acc = ir[8] ? (acc ^ ir[7:0]) : (acc + ir[7:0]);
            FPFEP_OP_LDI: next_acc = ir[7:0];
            FPFEP_OP_ROT: next_acc = {acc[0], acc[7:1]};
            FPFEP_OP_INC: next_acc = ir[8] ? (acc - 8'h01) : (acc + 8'h01);
            FPFEP_OP_JMP: next_redirect = 1'b1;
            FPFEP_OP_CALL: next_redirect = 1'b1;
            FPFEP_OP_RET: next_redirect = 1'b1;
            FPFEP_OP_SKZ: next_skip = zero;
            default: next_acc = acc;
        endcase
    end

    // program counter and fetch in the fetch phase
    // [RULE2] advance and fetch
    // [RULE8] step or load
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            // reset holds a fetch of the reset address, so the first phase after release
            // is a real fetch and the counter already points past it
            pc <= PC_W'(`FPFEP_PC_RESET) + PC_W'(1);
            o_imem_addr <= `FPFEP_PC_RESET;
            o_imem_rd <= 1'b1;
        end else begin
            o_imem_rd <= (phase == FPFEP_PH_WB);
            if (phase == FPFEP_PH_WB) begin
                // [RULE6] transfer to target
                o_imem_addr <= redirect ? target : pc;
                pc <= (redirect ? target : pc) + PC_W'(1);
            end
        end
    end

    // latch fetched word one clock after the fetch phase, while memory still drives it
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            fetched <= `FPFEP_NOP;
        end else if (phase == FPFEP_PH_DEC) begin
            fetched <= i_imem_data;
        end
    end

    // instruction register loads at cycle boundary, overlapping fetch
    // [RULE4] overlap fetch
    // [RULE9] discard prefetched word
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            ir <= `FPFEP_NOP;
            flush <= 1'b1;
            squash <= 1'b0;
        end else if (phase == FPFEP_PH_WB) begin
            // flush marks the whole next cycle as a dummy slot
            ir <= squash ? `FPFEP_NOP : fetched;
            flush <= squash;
            squash <= 1'b0;
        end else if (phase == FPFEP_PH_EXE) begin
            // squash carries the discard decision from execute to the cycle boundary
            squash <= !flush & (next_redirect | next_skip);
        end
    end

    // execute in the last three phases, commit at the end of the third
    // [RULE3] decode and execute
    // [RULE5] branch takes two cycles
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            acc <= 8'h00;
            zero <= 1'b1;
            redirect <= 1'b0;
            target <= `FPFEP_PC_RESET;
            ret_pc <= `FPFEP_PC_RESET;
            o_retire <= 1'b0;
            o_dummy <= 1'b0;
        end else begin
            o_retire <= 1'b0;
            o_dummy <= 1'b0;
            if (phase == FPFEP_PH_EXE) begin
                o_dummy <= flush;
                o_retire <= !flush;
                redirect <= !flush & next_redirect;
                if (!flush) begin
                    acc <= next_acc;
                    zero <= (next_acc == 8'h00);
                    // [RULE6] obtain target
                    if (op == FPFEP_OP_RET) begin
                        target <= ret_pc;
                    end else begin
                        target <= ir[PC_W-1:0];
                    end
                    if (op == FPFEP_OP_CALL) begin
                        // return to the word after the call, the one being fetched now
                        ret_pc <= o_imem_addr;
                    end
                end
            end else if (phase == FPFEP_PH_WB) begin
                redirect <= 1'b0;
            end
        end
    end

    // status outputs from flops
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_phase <= FPFEP_PH_FETCH;
            o_acc <= 8'h00;
        end else begin
            o_phase <= phase;
            o_acc <= acc;
        end
    end

    // [RULE10] phase wraps
    AST_PHASE_ORDER: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        phase == FPFEP_PH_WB |=> phase == FPFEP_PH_FETCH) // [RULE10]
        else $error("phase did not wrap");
    // [RULE1] four phase cycle
    AST_FOUR_PHASE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        phase == FPFEP_PH_FETCH |=> phase == FPFEP_PH_DEC ##1 phase == FPFEP_PH_EXE
        ##1 phase == FPFEP_PH_WB) // [RULE1]
        else $error("phase order broken");
    // [RULE2] fetch strobe in fetch phase
    AST_FETCH_PHASE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_imem_rd |-> phase == FPFEP_PH_FETCH) // [RULE2]
        else $error("fetch outside fetch phase");
    // [RULE8] sequential step
    AST_PC_STEP: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        phase == FPFEP_PH_WB && !redirect |=> pc == $past(pc) + PC_W'(1)) // [RULE8]
        else $error("pc did not step by one");
    // [RULE6] transfer to target
    AST_BRANCH_ADDR: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        phase == FPFEP_PH_WB && redirect |=> o_imem_addr == $past(target)) // [RULE6]
        else $error("branch target not fetched");
    // [RULE9] dummy after redirect
    AST_DUMMY: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        phase == FPFEP_PH_EXE && !flush && next_redirect |=> ##4 o_dummy) // [RULE9]
        else $error("no dummy cycle after branch");
    // [RULE4] one retire per cycle
    AST_RETIRE_SPACING: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_retire |=> !o_retire [*3]) // [RULE4]
        else $error("retire spacing wrong");
    // [RULE3] commit only in execute phase
    AST_ACC_PHASE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        acc != $past(acc) |-> $past(phase) == FPFEP_PH_EXE) // [RULE3]
        else $error("acc changed outside execute");
    // [RULE5] branch costs two cycles
    AST_TWO_CYCLE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_retire && $past(next_redirect) |=> ##3 !o_retire ##4 1'b1) // [RULE5]
        else $error("branch not two cycles");
    // [RULE7] increment
    AST_ALU_INC: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        phase == FPFEP_PH_EXE && !flush && op == FPFEP_OP_INC && !ir[8]
        |=> acc == $past(acc) + 8'h01) // [RULE7]
        else $error("increment wrong");
endmodule

// ===== src/fpfep_regs.svh
// constants for the four phase fetch execute pipeline
`ifndef FPFEP_REGS_SVH
`define FPFEP_REGS_SVH
`define FPFEP_PC_W 10
`define FPFEP_INSN_W 14
`define FPFEP_PC_RESET 10'h000
`define FPFEP_NOP 14'h0000
`define FPFEP_OP_POS 11
`define FPFEP_OP_W 3
`define FPFEP_CLK_PERIOD_NS 50
`define FPFEP_PHASES 4
`endif

// ===== src/fpfep_pkg.sv
// types for the four phase fetch execute pipeline
package fpfep_pkg;
    // phase order, gray coded along the cycle
    typedef enum logic [1:0] {
        FPFEP_PH_FETCH = 2'b00,
        FPFEP_PH_DEC = 2'b01,
        FPFEP_PH_EXE = 2'b11,
        FPFEP_PH_WB = 2'b10
    } fpfep_phase_e;
    // opcode classes in bits 13:11
    typedef enum logic [2:0] {
        FPFEP_OP_ALU = 3'b000,
        FPFEP_OP_JMP = 3'b001,
        FPFEP_OP_CALL = 3'b010,
        FPFEP_OP_SKZ = 3'b011,
        FPFEP_OP_RET = 3'b100,
        FPFEP_OP_LDI = 3'b101,
        FPFEP_OP_ROT = 3'b110,
        FPFEP_OP_INC = 3'b111
    } fpfep_op_e;
endpackage

// ===== tb/fpfep_pmem.sv
// program memory model answering instruction fetches
`timescale 1ns/1ps
module fpfep_pmem (
    // clock
    input wire logic i_sys_clk,
    // fetch request
    input wire logic [9:0] i_addr,
    input wire logic i_rd,
    // instruction word
    output logic [13:0] o_data
);
    logic [13:0] mem [1024];
    logic live;
    // every word starts as a no-operation word
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 14'h0000;
        end
    end
    // a fetch is answered in the request clock and the one after
    always_ff @(posedge i_sys_clk) begin
        live <= i_rd;
    end
    // outside a fetch the word is inverted so stale data never matches
    assign o_data = (i_rd || live) ? mem[i_addr] : ~mem[i_addr];
endmodule

// ===== tb/tb_top.sv
// self-checking testbench for the four phase fetch execute core
`timescale 1ns/1ps
module tb_top;
    import fpfep_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [9:0] o_imem_addr;
    logic [13:0] i_imem_data;
    logic o_imem_rd, o_retire, o_dummy, pend;
    fpfep_phase_e o_phase, pph;
    logic [7:0] o_acc, pacc;
    logic [7:0] rv [7];
    logic [7:0] ea [22];
    logic [9:0] fa [22];
    int num_errors = 0, n_tests = 0, seed = 32'h0000_043e;
    int since, fi, ei, gap, k;
    string ev = "DRRRRRRRRRDRRDRRRRDRRD";
    fpfep_core i_fpfep_core (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .o_imem_addr(o_imem_addr), .o_imem_rd(o_imem_rd), .i_imem_data(i_imem_data),
        .o_phase(o_phase), .o_acc(o_acc), .o_retire(o_retire), .o_dummy(o_dummy));
    fpfep_pmem i_fpfep_pmem (.i_sys_clk(i_sys_clk), .i_addr(o_imem_addr),
        .i_rd(o_imem_rd), .o_data(i_imem_data));
    // 20 MHz clock
    always #25 i_sys_clk = ~i_sys_clk;
    // compare and count
    task automatic chk(input logic ok, input string nm, input logic [13:0] e, s);
        n_tests++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // phase that must follow a given phase
    function automatic fpfep_phase_e nxt(input fpfep_phase_e p);
        case (p)
            FPFEP_PH_FETCH: return FPFEP_PH_DEC;
            FPFEP_PH_DEC: return FPFEP_PH_EXE;
            FPFEP_PH_EXE: return FPFEP_PH_WB;
            default: return FPFEP_PH_FETCH;
        endcase
    endfunction
    // rotate right by one, the low bit wraps to the top
    function automatic logic [7:0] rotr(input logic [7:0] v);
        return {v[0], v[7:1]};
    endfunction
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // monitor of fetches, phases, retires and the accumulator
    always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            since = 0; fi = 0; ei = 0; gap = 0; pend = 1'b0;
        end else begin
            since++;
            if (since > 2) chk(o_phase === nxt(pph), "phase", 14'(nxt(pph)), 14'(o_phase));
            if (pend) chk(o_acc === pacc, "acc", 14'(pacc), 14'(o_acc));
            pend = 1'b0;
            gap++;
            if (o_imem_rd === 1'b1 && fi < 22) begin
                chk(o_imem_addr === fa[fi], "addr", 14'(fa[fi]), 14'(o_imem_addr));
                if (fi > 0) chk(gap == 4, "gap", 14'd4, 14'(gap));
                fi++;
                gap = 0;
            end
            if ((o_retire | o_dummy) === 1'b1 && ei < 22) begin
                chk(ev[ei] == (o_retire ? 8'h52 : 8'h44), "event", 14'(ev[ei]), 14'(o_retire));
                chk(!(o_retire && o_dummy), "both", 14'd0, 14'd1);
                pend = o_retire;
                pacc = ea[ei];
                ei++;
            end
        end
        pph = o_phase;
    end
    // program: random loads, wrap by inc, taken skip, wrap by dec, call, rotate, xor, return, add,
    // then a jump loop
    initial begin
        #2;
        for (k = 0; k < 7; k++) begin
            rv[k] = 8'($random(seed));
            if (k < 6) i_fpfep_pmem.mem[k] = 14'h2800 | 14'(rv[k]);
            if (k < 6) ea[k+1] = rv[k];
        end
        i_fpfep_pmem.mem[6] = 14'h28ff;
        i_fpfep_pmem.mem[7] = 14'h3800;
        i_fpfep_pmem.mem[8] = 14'h1800;
        i_fpfep_pmem.mem[9] = 14'h2855;
        i_fpfep_pmem.mem[10] = 14'h3900;
        i_fpfep_pmem.mem[11] = 14'h1100; // call 256
        i_fpfep_pmem.mem[12] = 14'(rv[0]); // add, first word after the return
        i_fpfep_pmem.mem[13] = 14'h080d; // jump to itself
        i_fpfep_pmem.mem[14] = 14'h2811; // prefetched and discarded
        i_fpfep_pmem.mem[256] = 14'h2800 | 14'(rv[6]);
        i_fpfep_pmem.mem[257] = 14'h3000; // rotate right
        i_fpfep_pmem.mem[258] = 14'h015a; // xor
        i_fpfep_pmem.mem[259] = 14'h2000; // return
        i_fpfep_pmem.mem[260] = 14'h28aa; // prefetched and discarded
        for (k = 0; k < 18; k++) fa[k] = (k < 13) ? 10'(k) : 10'(243 + k);
        fa[18] = 10'h00c;
        fa[19] = 10'h00d;
        fa[20] = 10'h00e;
        fa[21] = 10'h00d;
        ea[7] = 8'hff;
        ea[8] = 8'h00;
        ea[9] = 8'h00;
        ea[11] = 8'hff;
        ea[12] = 8'hff;
        ea[14] = rv[6];
        ea[15] = rotr(rv[6]);
        ea[16] = ea[15] ^ 8'h5a;
        ea[17] = ea[16];
        ea[19] = ea[17] + rv[0];
        ea[20] = ea[19];
        // two runs, the second reset lands in mid-run
        for (int run = 0; run < 2; run++) begin
            @(posedge i_sys_clk);
            #1 i_sys_rst = 1'b1;
            repeat (20) @(posedge i_sys_clk);
            #1 i_sys_rst = 1'b0;
            for (k = 0; k < 400 && ei < 22; k++) begin
                @(posedge i_sys_clk);
                #1;
            end
            chk(ei == 22, "events", 14'd22, 14'(ei));
            chk(fi == 22, "fetches", 14'd22, 14'(fi));
            if (ei != 22) test_done;
            repeat (9) @(posedge i_sys_clk);
            $display("run %0d done", run);
        end
        test_done;
    end
endmodule
